// ===== core/bli2c_core.sv
/*
 * Bit-level I2C interface: control/status and one-bit data registers, clock
 * stretching, arbitration and start/stop detection, restart/stop generation.
 * Assumes a register port on mclk_in with read data one cycle after the strobe,
 * and open-drain bus pins resolved outside; bus pins are asynchronous.
 */
// Functional notes
// - Each rising SCL edge samples SDA into the received bit.
// - Data register reads received bit in bit 7, zeros below; read clears ready.
// - Attention is the OR of ready, arbitration-lost, start and stop flags.
// - Ready sets on every rising SCL edge unless idle slave.
// - Ready clears on clear command, or any data register read or write.
// - SCL held low after ready set until software clears ready.
// - Idle command makes slave ignore bus until next start.
// - Data write bit 7 is next bit to transmit.
// - Data write clears ready and sets transmit-active.
// - Any of arbitration, start, stop flags keeps SCL stretched.
// - SDA driven low and arbitration loss only while transmit-active; loss clears it.
// - Clear-transmit-active command or data register read clears transmit-active.
// - Clear commands for arbitration, start, stop clear their flags.
// - Restart or stop command sets transmit-active and shapes SDA for the condition.
`include "bli2c_defs.svh"
module bli2c_core
	import bli2c_pkg::*;
(
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	input  wire bli2c_pkg::bli2c_addr_t addr_in,
	input  wire bli2c_pkg::bli2c_byte_t wdata_in,
	input  wire logic               wr_in,
	input  wire logic               rd_in,
	output bli2c_pkg::bli2c_byte_t  rdata_out,
	input  wire logic               scl_in,
	output logic                    scl_out,
	output logic                    scl_oe_out,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe_out,
	output logic                    irq_out
);
	import bli2c_pkg::*;

	logic       scl_s, sda_s, scl_prev_q, sda_prev_q;
	logic       rxbit_q, rdy_q, arb_q, start_q, stop_q, master_q, idle_q, txa_q, txbit_q;
	logic       mreq_q, busy_q, scl_low_q, sda_low_q, holdstate_q;
	bli2c_cmd_t cmd_q;
	logic       scl_rise, scl_fall, start_det, stop_det, attn;
	logic       wr_ctrl, wr_data, rd_data, rd_ctrl;
	logic [`BLI2C_NEVENTS-1:0] ev_stat, ev_mask, ev_set, ev_clr;

	bli2c_sync u_sync_scl (
		.clk_in (mclk_in),
		.rst_in (rst_in),
		.d_in   (scl_in),
		.q_out  (scl_s)
	);
	bli2c_sync u_sync_sda (
		.clk_in (mclk_in),
		.rst_in (rst_in),
		.d_in   (sda_in),
		.q_out  (sda_s)
	);

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign attn      = rdy_q | arb_q | start_q | stop_q;

	assign wr_ctrl = wr_in && (addr_in == `BLI2C_OFF_CTRL);
	assign wr_data = wr_in && (addr_in == `BLI2C_OFF_DATA);
	assign rd_data = rd_in && (addr_in == `BLI2C_OFF_DATA);
	assign rd_ctrl = rd_in && (addr_in == `BLI2C_OFF_CTRL);

	// Idle slave wakes only at a start; the idle command is ignored while master
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			idle_q <= 1'b0;
		else if (start_det)
			idle_q <= 1'b0;
		else if (wr_ctrl && wdata_in[`BLI2C_W_IDLE] && !master_q)
			idle_q <= 1'b1;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			rxbit_q <= 1'b1;
		else if (scl_rise)
			rxbit_q <= sda_s;
	end

	// Set wins over any clear in the same cycle
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			rdy_q <= 1'b0;
		else if (scl_rise && !idle_q)
			rdy_q <= 1'b1;
		else if (wr_data || rd_data || (wr_ctrl && wdata_in[`BLI2C_W_CLR_RDY]))
			rdy_q <= 1'b0;
	end

	// Loss: we released SDA (sent 1) but bus shows 0 at SCL rise
	logic arb_hit;
	assign arb_hit = txa_q && scl_rise && txbit_q && !sda_s;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			arb_q <= 1'b0;
		else if (arb_hit)
			arb_q <= 1'b1;
		else if (wr_ctrl && wdata_in[`BLI2C_W_CLR_ARB])
			arb_q <= 1'b0;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			start_q <= 1'b0;
		else if (start_det && !idle_q)
			start_q <= 1'b1;
		else if (wr_ctrl && wdata_in[`BLI2C_W_CLR_START])
			start_q <= 1'b0;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			stop_q <= 1'b0;
		else if (stop_det && !idle_q)
			stop_q <= 1'b1;
		else if (wr_ctrl && wdata_in[`BLI2C_W_CLR_STOP])
			stop_q <= 1'b0;
	end

	// Transmit-active and the bit or condition to send
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			txa_q   <= 1'b0;
			txbit_q <= 1'b1;
			cmd_q   <= BLI2C_CMD_BIT;
		end else if (arb_hit) begin
			txa_q <= 1'b0;
		end else if (wr_data) begin
			txa_q   <= 1'b1;
			txbit_q <= wdata_in[`BLI2C_B_RXBIT];
			cmd_q   <= BLI2C_CMD_BIT;
		end else if (wr_ctrl && wdata_in[`BLI2C_W_RESTART]) begin
			txa_q   <= 1'b1;
			txbit_q <= 1'b1;
			cmd_q   <= BLI2C_CMD_RESTART;
		end else if (wr_ctrl && wdata_in[`BLI2C_W_STOPCMD]) begin
			txa_q   <= 1'b1;
			txbit_q <= 1'b0;
			cmd_q   <= BLI2C_CMD_STOP;
		end else if (rd_data || (wr_ctrl && wdata_in[`BLI2C_W_CLR_TXA])) begin
			txa_q <= 1'b0;
		end else if (start_det || stop_det) begin
			cmd_q <= BLI2C_CMD_BIT;
		end
	end

	// Bus ownership: request bit in a config register, master when bus free
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			mreq_q <= 1'b0;
		else if (wr_in && addr_in == `BLI2C_OFF_CFG)
			mreq_q <= wdata_in[`BLI2C_CFG_MREQ];
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			busy_q <= 1'b0;
		else if (start_det)
			busy_q <= 1'b1;
		else if (stop_det)
			busy_q <= 1'b0;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			master_q <= 1'b0;
		else if (arb_hit || (stop_det && !mreq_q))
			master_q <= 1'b0;
		else if (mreq_q && !busy_q)
			master_q <= 1'b1;
	end

	// Stretch: hold SCL low from the next fall until all flags are serviced
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			holdstate_q <= 1'b0;
		else if (scl_fall && attn && !idle_q)
			holdstate_q <= 1'b1;
		else if (!attn)
			holdstate_q <= 1'b0;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			scl_low_q <= 1'b0;
		else
			scl_low_q <= (holdstate_q && attn) || (scl_fall && attn && !idle_q);
	end

	// SDA shaping: data during low phase; restart pulls low, stop releases, while high
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			sda_low_q <= 1'b0;
		else if (!txa_q)
			sda_low_q <= 1'b0;
		else if (!scl_s)
			sda_low_q <= !txbit_q;
		else if (scl_prev_q && cmd_q == BLI2C_CMD_RESTART)
			sda_low_q <= 1'b1;
		else if (scl_prev_q && cmd_q == BLI2C_CMD_STOP)
			sda_low_q <= 1'b0;
	end

	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign scl_oe_out = scl_low_q;
	assign sda_oe_out = sda_low_q;

	// Read data, valid the cycle after the strobe; control writes are one-shot
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			rdata_out <= `BLI2C_ZERO8;
		else if (rd_ctrl)
			rdata_out <= {rxbit_q, attn, rdy_q, arb_q, start_q, stop_q, master_q, 1'b1};
		else if (rd_data)
			rdata_out <= {rxbit_q, `BLI2C_ZERO7};
		else if (rd_in && addr_in == `BLI2C_OFF_INT_STAT)
			rdata_out <= {4'h0, ev_stat};
		else if (rd_in && addr_in == `BLI2C_OFF_INT_MASK)
			rdata_out <= {4'h0, ev_mask};
		else if (rd_in && addr_in == `BLI2C_OFF_CFG)
			rdata_out <= {7'h00, mreq_q};
		else
			rdata_out <= `BLI2C_ZERO8;
	end

	assign ev_set = {scl_rise && !idle_q, arb_hit, start_det && !idle_q, stop_det && !idle_q};
	assign ev_clr = (wr_in && addr_in == `BLI2C_OFF_INT_STAT) ? wdata_in[`BLI2C_NEVENTS-1:0] : `BLI2C_ZERO_EV;

	bli2c_irq u_irq (
		.clk_in     (mclk_in),
		.rst_in     (rst_in),
		.event_in   (ev_set),
		.clear_in   (ev_clr),
		.mask_we_in (wr_in && addr_in == `BLI2C_OFF_INT_MASK),
		.mask_in    (wdata_in[`BLI2C_NEVENTS-1:0]),
		.status_out (ev_stat),
		.mask_out   (ev_mask),
		.irq_out    (irq_out)
	);
endmodule : bli2c_core

// ===== core/bli2c_defs.svh
/*
 * Offsets, field positions, reset values and interrupt layout of the bit-level I2C block.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef BLI2C_DEFS_SVH
`define BLI2C_DEFS_SVH

`define BLI2C_ADDR_W        8
`define BLI2C_OFF_CTRL      8'hd8
`define BLI2C_OFF_DATA      8'hd9
`define BLI2C_OFF_INT_STAT  8'hda
`define BLI2C_OFF_INT_MASK  8'hdb
`define BLI2C_OFF_CFG       8'hdc
`define BLI2C_CTRL_RESET    8'h81

`define BLI2C_B_RXBIT       7
`define BLI2C_B_ATTN        6
`define BLI2C_B_RDY         5
`define BLI2C_B_ARB         4
`define BLI2C_B_START       3
`define BLI2C_B_STOP        2
`define BLI2C_B_MASTER      1
`define BLI2C_B_UNDEF       0

`define BLI2C_W_CLR_TXA     7
`define BLI2C_W_IDLE        6
`define BLI2C_W_CLR_RDY     5
`define BLI2C_W_CLR_ARB     4
`define BLI2C_W_CLR_START   3
`define BLI2C_W_CLR_STOP    2
`define BLI2C_W_RESTART     1
`define BLI2C_W_STOPCMD     0

`define BLI2C_CFG_MREQ      0
`define BLI2C_NEVENTS       4
`define BLI2C_ZERO7         7'h00
`define BLI2C_ZERO8         8'h00
`define BLI2C_ZERO_EV       4'h0

`endif

// ===== core/bli2c_irq.sv
/*
 * Sticky event status, mask and level interrupt.
 * Assumes one-cycle event pulses and write-one-to-clear strobes on the same clock.
 */
`include "bli2c_defs.svh"
module bli2c_irq (
	input  wire logic                       clk_in,
	input  wire logic                       rst_in,
	input  wire logic [`BLI2C_NEVENTS-1:0]  event_in,
	input  wire logic [`BLI2C_NEVENTS-1:0]  clear_in,
	input  wire logic                       mask_we_in,
	input  wire logic [`BLI2C_NEVENTS-1:0]  mask_in,
	output logic      [`BLI2C_NEVENTS-1:0]  status_out,
	output logic      [`BLI2C_NEVENTS-1:0]  mask_out,
	output logic                            irq_out
);
	genvar i;
	generate
		for (i = 0; i < `BLI2C_NEVENTS; i++) begin : g_ev
			// Set beats clear in the same cycle
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in)
					status_out[i] <= 1'b0;
				else if (event_in[i])
					status_out[i] <= 1'b1;
				else if (clear_in[i])
					status_out[i] <= 1'b0;
			end
		end
	endgenerate
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			mask_out <= `BLI2C_ZERO_EV;
		else if (mask_we_in)
			mask_out <= mask_in;
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(((status_out | event_in) & ~clear_in | event_in) & mask_out);
	end
endmodule : bli2c_irq

// ===== core/bli2c_pkg.sv
/*
 * Types shared by the bit-level I2C block.
 * Assumes the constants header sits beside it.
 */
`include "bli2c_defs.svh"
package bli2c_pkg;
	typedef logic [`BLI2C_ADDR_W-1:0] bli2c_addr_t;
	typedef logic [7:0]               bli2c_byte_t;
	typedef enum logic [1:0] {BLI2C_CMD_BIT, BLI2C_CMD_RESTART, BLI2C_CMD_STOP} bli2c_cmd_t;
endpackage : bli2c_pkg

// ===== core/bli2c_sync.sv
/*
 * Two-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to clk_in.
 */
module bli2c_sync (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_q;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= 1'b1;
			q_out  <= 1'b1;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule : bli2c_sync

// ===== verification/bli2c_asserts.sv
/* Checker for the bit-level I2C core: register read path and bus pins.
   Assumes the core's ports and the defs header on the include path. */
`include "bli2c_defs.svh"
module bli2c_asserts
	import bli2c_pkg::*;
(
	input  wire logic                   mclk_in,
	input  wire logic                   rst_in,
	input  wire bli2c_pkg::bli2c_addr_t addr_in,
	input  wire logic                   wr_in,
	input  wire logic                   rd_in,
	input  wire bli2c_pkg::bli2c_byte_t rdata_out,
	input  wire logic                   scl_in,
	input  wire logic                   scl_oe_out,
	input  wire logic                   sda_oe_out
);
	logic [2:0] calm_q;
	// SCL quiet long enough that no sync-delayed edge can set ready
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			calm_q <= 3'h0;
		else if ($changed(scl_in))
			calm_q <= 3'h0;
		else if (calm_q != 3'h7)
			calm_q <= calm_q + 3'h1;
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence rd_ctrl; rd_in && addr_in == `BLI2C_OFF_CTRL; endsequence
	sequence rd_data; rd_in && addr_in == `BLI2C_OFF_DATA; endsequence
	sequence calm_pair; calm_q == 3'h7 ##0 rd_data ##2 rd_ctrl; endsequence
	rd_quiet_a: assert property (!rd_in |=> rdata_out == 8'h00) else $error("read data not idle");
	data_low_a: assert property (rd_data |=> rdata_out[6:0] == 7'h00) else $error("data low bits set");
	ctrl_undef_a: assert property (rd_ctrl |=> rdata_out[0]) else $error("control bit 0 low");
	attn_sum_a: assert property (rd_ctrl |=> rdata_out[6] == |rdata_out[5:2]) else $error("attention wrong");
	ready_clr_a: assert property (calm_pair |=> !rdata_out[5]) else $error("ready kept after data read");
	rx_echo_a: assert property (calm_pair |=> rdata_out[7] == $past(rdata_out[7], 2)) else $error("bit views differ");
	scl_hold_a: assert property (scl_oe_out && !wr_in && !rd_in && !$past(wr_in) && !$past(rd_in) |=> scl_oe_out)
		else $error("clock stretch dropped");
	tx_quiet_a: assert property (rd_data ##1 (!wr_in)[*2] |=> !sda_oe_out) else $error("data driven idle");
endmodule : bli2c_asserts
bind bli2c_core bli2c_asserts bli2c_asserts_inst (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_in), .scl_oe_out(scl_oe_out),
	.sda_oe_out(sda_oe_out));

// ===== verification/bli2c_bus_model.sv
/* Behavioural I2C master facing the core's bus pins.
   Assumes the bench resolves both wires with pull-ups. */
module bli2c_bus_model (
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_oe_out,
	output logic      sda_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ack_q = 1'b1;
	initial {scl_oe_out, sda_oe_out} = 2'b00;
	task automatic bit_clk(input logic b);
		sda_oe_out = !b;
		#400 scl_oe_out = 1'b0;
		wait (scl_in);
		// Sample mid-high: the core may release SCL and set SDA on one edge
		#200 ack_q = sda_in;
		#200 scl_oe_out = 1'b1;
	endtask : bit_clk
	task automatic frame(input logic [7:0] b);
		sda_oe_out = 1'b1;
		#400 scl_oe_out = 1'b1;
		for (int i = 7; i >= 0; i--)
			bit_clk(b[i]);
		bit_clk(1'b1);
		sda_oe_out = 1'b1;
		#400 scl_oe_out = 1'b0;
		wait (scl_in);
		#400 sda_oe_out = 1'b0;
	endtask : frame
endmodule : bli2c_bus_model

// ===== verification/bli2c_core_tb.sv
/* Self-checking bench for bli2c_core against a behavioural bus master.
   Assumes core, checker and model compiled before it. */
`include "bli2c_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED %0t got %h", $time, g); end end
module bli2c_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bli2c_pkg::*;
	localparam bli2c_byte_t PAT = 8'ha6;
	logic        mclk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
	bli2c_addr_t addr_in = 8'h00;
	bli2c_byte_t wdata_in = 8'h00, rdata_out, v;
	logic        scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out, m_scl_oe, m_sda_oe;
	int          n_fail = 0, comparisons = 0, cycles = 0;
	wire logic   scl_w = !(scl_oe_out || m_scl_oe);
	wire logic   sda_w = !(sda_oe_out || m_sda_oe);
	bli2c_core bli2c_core_inst (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.scl_in(scl_w), .scl_out, .scl_oe_out, .sda_in(sda_w), .sda_out, .sda_oe_out, .irq_out);
	bli2c_bus_model bm_inst (.scl_in(scl_w), .sda_in(sda_w), .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe));
	always #50 mclk_in = ~mclk_in;
	task automatic test_done;
		$display("Mismatches %0d of %0d comparisons", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			test_done();
		end
	end
	task automatic wr(input bli2c_addr_t a, input bli2c_byte_t d);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input bli2c_addr_t a, output bli2c_byte_t d);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : rd
	task automatic poll(input bli2c_byte_t m, output bli2c_byte_t d);
		for (int i = 0; i < 200; i++) begin
			rd(`BLI2C_OFF_CTRL, d);
			if ((d & m) != 8'h00)
				break;
		end
	endtask : poll
	initial begin
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		rd(`BLI2C_OFF_CTRL, v);
		`CHK(v, `BLI2C_CTRL_RESET)
		wr(8'hee, 8'hff);
		rd(8'hee, v);
		`CHK(v, 8'h00)
		wr(`BLI2C_OFF_INT_STAT, 8'h0f);
		wr(`BLI2C_OFF_INT_MASK, 8'h0d);
		fork
			bm_inst.frame(PAT);
			begin
				poll(8'h08, v);
				`CHK(v[6], 1'b1)
				wr(`BLI2C_OFF_CTRL, 8'h00);
				rd(`BLI2C_OFF_CTRL, v);
				`CHK(v[3], 1'b1)
				repeat (8) @(posedge mclk_in);
				`CHK(scl_oe_out, 1'b1)
				`CHK(irq_out, 1'b0)
				wr(`BLI2C_OFF_INT_MASK, 8'h0f);
				repeat (3) @(posedge mclk_in);
				`CHK(irq_out, 1'b1)
				wr(`BLI2C_OFF_INT_STAT, 8'h0f);
				wr(`BLI2C_OFF_INT_MASK, 8'h0d);
				repeat (3) @(posedge mclk_in);
				`CHK(irq_out, 1'b0)
				wr(`BLI2C_OFF_CTRL, 8'h08);
				for (int i = 7; i >= 0; i--) begin
					poll(8'h20, v);
					`CHK(v[7], PAT[i])
					rd(`BLI2C_OFF_CTRL, v);
					`CHK(v[5], 1'b1)
					if (i > 0) begin
						rd(`BLI2C_OFF_DATA, v);
						`CHK(v, {PAT[i], 7'h00})
					end else
						wr(`BLI2C_OFF_DATA, 8'h00);
				end
				poll(8'h20, v);
				rd(`BLI2C_OFF_DATA, v);
				`CHK(v, 8'h00)
				poll(8'h04, v);
				wr(`BLI2C_OFF_CTRL, 8'h24);
				rd(`BLI2C_OFF_CTRL, v);
				`CHK(v, 8'h01)
			end
		join
		`CHK(bm_inst.ack_q, 1'b0)
		wr(`BLI2C_OFF_CTRL, 8'h40);
		bm_inst.bit_clk(1'b1);
		bm_inst.bit_clk(1'b1);
		rd(`BLI2C_OFF_CTRL, v);
		`CHK(v[6:5], 2'b00)
		repeat (8) @(posedge mclk_in);
		rd(`BLI2C_OFF_DATA, v);
		`CHK(v, 8'h80)
		rd(`BLI2C_OFF_CTRL, v);
		`CHK(v[5], 1'b0)
		test_done();
	end
endmodule : bli2c_core_tb
